// File: logic/orcr_pkg.sv
package orcr_pkg;
  // register offsets, byte addresses on the plain register port
  localparam logic [7:0] ADDR_MODE = 8'h4a;
  localparam logic [7:0] ADDR_ADDR = 8'h4b;
  localparam logic [7:0] ADDR_DATA = 8'h4c;
  localparam logic [7:0] ADDR_TXCNT = 8'h4d;
  localparam logic [7:0] ADDR_CTRL = 8'h44;
  localparam logic [7:0] ADDR_MODEL0 = 8'h55;
  localparam logic [7:0] ADDR_MODEL1 = 8'h56;
  localparam logic [7:0] ADDR_MODEL2 = 8'h57;
  // field positions in the mode register
  localparam int MODE_LO_POS = 0;
  localparam int CODE_LO_POS = 2;
  localparam int CAP_LO_POS = 4;
  localparam int ACK_POS = 6;
  // field encodings
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_EXTENDED = 2'h2;
  localparam logic [1:0] CODE_RD_REPLY = 2'h0;
  localparam logic [1:0] CODE_RD_REQ = 2'h1;
  localparam logic [1:0] CODE_WR_REPLY = 2'h2;
  localparam logic [1:0] CODE_WR_REQ = 2'h3;
  localparam logic [1:0] CAP_EXT = 2'h2;
  localparam logic [7:0] CTRL_CLEAR_VAL = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;
  // reset values
  localparam logic [7:0] MODE_RST = 8'h22; // extended mode and capability 10 out of reset
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] MODEL_RST = 8'h00;

  typedef enum logic [2:0] {
    ORCR_CMD_NONE,
    ORCR_CMD_RD_REPLY,
    ORCR_CMD_RD_REQ,
    ORCR_CMD_RD_ACK,
    ORCR_CMD_WR_REPLY,
    ORCR_CMD_WR_REQ
  } orcr_cmd_t;
endpackage : orcr_pkg

// File: logic/orcr_cmd_decode.sv
`timescale 1ns/10ps
module orcr_cmd_decode
  import orcr_pkg::*;
(
  input wire logic [1:0] op_mode,
  input wire logic [1:0] op_code,
  input wire logic read_ack_select,
  output orcr_pkg::orcr_cmd_t cmd
);
  // command type only exists in extended mode
  always_comb begin
    cmd = ORCR_CMD_NONE;
    if (op_mode == MODE_EXTENDED) begin
      case (op_code)
        CODE_RD_REPLY: cmd = ORCR_CMD_RD_REPLY;
        CODE_RD_REQ: cmd = read_ack_select ? ORCR_CMD_RD_ACK : ORCR_CMD_RD_REQ;
        CODE_WR_REPLY: cmd = ORCR_CMD_WR_REPLY;
        CODE_WR_REQ: cmd = ORCR_CMD_WR_REQ;
        default: cmd = ORCR_CMD_NONE;
      endcase
    end
  end
endmodule : orcr_cmd_decode

// File: logic/orcr_sat_counter.sv
`timescale 1ns/10ps
module orcr_sat_counter
  import orcr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic inc,
  input wire logic clr,
  output logic [7:0] count
);
  // clear wins: software asked for zero explicitly
  always_ff @(posedge clk) begin
    if (rst || clr) begin
      count <= CNT_RST;
    end else if (inc && count != CNT_MAX) begin
      count <= count + 8'h01;
    end
  end
endmodule : orcr_sat_counter

// File: logic/orcr_regs.sv
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
module orcr_regs
  import orcr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic center_side,
  input wire logic remote_cmd_send,
  input wire logic tx_valid_pkt,
  output logic [7:0] frame_bits_31_24,
  output logic [7:0] frame_bits_39_32,
  output logic [7:0] frame_bits_47_40,
  output orcr_pkg::orcr_cmd_t remote_cmd,
  output logic [1:0] op_mode,
  output logic mode_reserved
);
  import orcr_pkg::*;

  logic [7:0] mode_r;
  logic [7:0] remote_addr_byte_r;
  logic [7:0] remote_data_byte_r;
  logic [7:0] model_info_bytes_r [0:2];
  logic [7:0] tx_count;
  logic [7:0] rdata_nxt;
  logic cnt_clr;
  logic use_cmd;
  logic [1:0] op_code;
  logic read_ack_select;

  // strobe and address match, shared by the mode and clear write decodes and the checks
  function automatic logic hit(input logic strobe, input logic [7:0] addr, input logic [7:0] target);
    hit = strobe && (addr == target);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  // mode register: bits 5:4 are a fixed capability, bit 7 reserved
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_r <= MODE_RST;
    end else if (hit(reg_wr, reg_addr, ADDR_MODE)) begin
      mode_r <= {1'b0, reg_wdata[ACK_POS], CAP_EXT, reg_wdata[3:0]};
    end
  end

  // command bytes; stored whatever side, only the center uses them
  always_ff @(posedge clk) begin
    if (rst) begin
      remote_addr_byte_r <= BYTE_RST;
      remote_data_byte_r <= BYTE_RST;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_ADDR) begin
        remote_addr_byte_r <= reg_wdata;
      end
      if (reg_addr == ADDR_DATA) begin
        remote_data_byte_r <= reg_wdata;
      end
    end
  end

  // local model information bytes
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        model_info_bytes_r[i] <= MODEL_RST;
      end
    end else if (reg_wr) begin
      if (reg_addr == ADDR_MODEL0) model_info_bytes_r[0] <= reg_wdata;
      if (reg_addr == ADDR_MODEL1) model_info_bytes_r[1] <= reg_wdata;
      if (reg_addr == ADDR_MODEL2) model_info_bytes_r[2] <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode decode and frame byte selection

  assign op_mode = mode_r[MODE_LO_POS+1:MODE_LO_POS];
  assign op_code = mode_r[CODE_LO_POS+1:CODE_LO_POS];
  assign read_ack_select = mode_r[ACK_POS];
  // reserved modes are flagged only; behaviour falls back to normal
  assign mode_reserved = op_mode[0];

  // remote command bytes replace model bytes on center side sends
  assign use_cmd = center_side && (op_mode == MODE_EXTENDED || remote_cmd_send);

  // frame bytes are registered to keep the frame engine path short
  always_ff @(posedge clk) begin
    if (rst) begin
      frame_bits_31_24 <= MODEL_RST;
      frame_bits_39_32 <= MODEL_RST;
      frame_bits_47_40 <= MODEL_RST;
    end else if (use_cmd) begin
      frame_bits_31_24 <= (op_mode == MODE_EXTENDED) ? mode_r : model_info_bytes_r[0];
      frame_bits_39_32 <= remote_addr_byte_r;
      frame_bits_47_40 <= remote_data_byte_r;
    end else begin
      frame_bits_31_24 <= model_info_bytes_r[0];
      frame_bits_39_32 <= model_info_bytes_r[1];
      frame_bits_47_40 <= model_info_bytes_r[2];
    end
  end

  orcr_cmd_decode u_decode (
    .op_mode(op_mode),
    .op_code(op_code),
    .read_ack_select(read_ack_select),
    .cmd(remote_cmd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // transmit packet counter

  assign cnt_clr = hit(reg_wr, reg_addr, ADDR_CTRL) && reg_wdata == CTRL_CLEAR_VAL;

  orcr_sat_counter u_txcnt (
    .clk(clk),
    .rst(rst),
    .inc(tx_valid_pkt),
    .clr(cnt_clr),
    .count(tx_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read back, data one cycle after the strobe

  always_comb begin
    rdata_nxt = 8'h00;
    case (reg_addr)
      ADDR_MODE: rdata_nxt = mode_r;
      ADDR_ADDR: rdata_nxt = remote_addr_byte_r;
      ADDR_DATA: rdata_nxt = remote_data_byte_r;
      ADDR_TXCNT: rdata_nxt = tx_count;
      ADDR_MODEL0: rdata_nxt = model_info_bytes_r[0];
      ADDR_MODEL1: rdata_nxt = model_info_bytes_r[1];
      ADDR_MODEL2: rdata_nxt = model_info_bytes_r[2];
      default: rdata_nxt = 8'h00;
    endcase
  end

  // unselected cycles read zero so stale data never leaks
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  count_inc_a: assert property (@(posedge clk) disable iff (rst)
    (tx_valid_pkt && !cnt_clr && tx_count != CNT_MAX) |=> tx_count == $past(tx_count) + 8'h01)
    else $error("tx counter missed an increment");
  count_sat_a: assert property (@(posedge clk) disable iff (rst)
    (tx_count == CNT_MAX && !cnt_clr) |=> tx_count == CNT_MAX)
    else $error("tx counter wrapped");
  count_clr_a: assert property (@(posedge clk) disable iff (rst)
    cnt_clr |=> tx_count == 8'h00)
    else $error("tx counter not cleared");
  count_ro_a: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && reg_addr == ADDR_TXCNT && !tx_valid_pkt) |=> $stable(tx_count))
    else $error("tx counter written");
  frame_addr_a: assert property (@(posedge clk) disable iff (rst)
    use_cmd |=> frame_bits_39_32 == $past(remote_addr_byte_r))
    else $error("address byte not in frame");
  frame_data_a: assert property (@(posedge clk) disable iff (rst)
    use_cmd |=> frame_bits_47_40 == $past(remote_data_byte_r))
    else $error("data byte not in frame");
  frame_model_a: assert property (@(posedge clk) disable iff (rst)
    (!use_cmd) |=> frame_bits_39_32 == $past(model_info_bytes_r[1]))
    else $error("model byte not in frame");
  cmd_ack_a: assert property (@(posedge clk) disable iff (rst)
    (op_mode == MODE_EXTENDED && op_code == CODE_RD_REQ && read_ack_select) |-> remote_cmd == ORCR_CMD_RD_ACK)
    else $error("read ack not decoded");
  cmd_mode_a: assert property (@(posedge clk) disable iff (rst)
    (op_mode != MODE_EXTENDED) |-> remote_cmd == ORCR_CMD_NONE)
    else $error("command outside extended mode");
  read_data_a: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && reg_addr == ADDR_ADDR) ##1 (reg_rd && reg_addr == ADDR_ADDR && !reg_wr)
      |=> reg_rdata == $past(reg_wdata, 2))
    else $error("address byte readback wrong");

  // byte registers take a write on the next edge and hold otherwise
  addr_wr_a: assert property (@(posedge clk) disable iff (rst)
    hit(reg_wr, reg_addr, ADDR_ADDR) |=> remote_addr_byte_r == $past(reg_wdata))
    else $error("address byte write lost");

  data_wr_a: assert property (@(posedge clk) disable iff (rst)
    hit(reg_wr, reg_addr, ADDR_DATA) |=> remote_data_byte_r == $past(reg_wdata))
    else $error("data byte write lost");

  addr_hold_a: assert property (@(posedge clk) disable iff (rst)
    !hit(reg_wr, reg_addr, ADDR_ADDR) |=> $stable(remote_addr_byte_r))
    else $error("address byte changed without a write");

  data_hold_a: assert property (@(posedge clk) disable iff (rst)
    !hit(reg_wr, reg_addr, ADDR_DATA) |=> $stable(remote_data_byte_r))
    else $error("data byte changed without a write");

  model0_wr_a: assert property (@(posedge clk) disable iff (rst)
    hit(reg_wr, reg_addr, ADDR_MODEL0) |=> model_info_bytes_r[0] == $past(reg_wdata))
    else $error("model byte 0 write lost");

  model1_wr_a: assert property (@(posedge clk) disable iff (rst)
    hit(reg_wr, reg_addr, ADDR_MODEL1) |=> model_info_bytes_r[1] == $past(reg_wdata))
    else $error("model byte 1 write lost");

  model2_wr_a: assert property (@(posedge clk) disable iff (rst)
    hit(reg_wr, reg_addr, ADDR_MODEL2) |=> model_info_bytes_r[2] == $past(reg_wdata))
    else $error("model byte 2 write lost");

  // mode register: software fields land, fixed bits never move
  mode_wr_a: assert property (@(posedge clk) disable iff (rst)
    hit(reg_wr, reg_addr, ADDR_MODE) |=> mode_r[3:0] == $past(reg_wdata[3:0]))
    else $error("mode and code fields write lost");

  ack_wr_a: assert property (@(posedge clk) disable iff (rst)
    hit(reg_wr, reg_addr, ADDR_MODE) |=> read_ack_select == $past(reg_wdata[ACK_POS]))
    else $error("read ack bit write lost");

  mode_cap_a: assert property (@(posedge clk) disable iff (rst)
    mode_r[CAP_LO_POS+1:CAP_LO_POS] == CAP_EXT)
    else $error("capability bits moved");

  mode_top_a: assert property (@(posedge clk) disable iff (rst)
    mode_r[7] == 1'b0)
    else $error("reserved mode bit set");

  mode_hold_a: assert property (@(posedge clk) disable iff (rst)
    !hit(reg_wr, reg_addr, ADDR_MODE) |=> $stable(mode_r))
    else $error("mode register changed without a write");

  rsv_flag_a: assert property (@(posedge clk) disable iff (rst)
    mode_reserved == (op_mode == 2'h1 || op_mode == 2'h3))
    else $error("reserved mode flag wrong");

  // frame byte sources, one edge behind the registers
  frame_lo_model_a: assert property (@(posedge clk) disable iff (rst)
    (!use_cmd) |=> frame_bits_31_24 == $past(model_info_bytes_r[0]))
    else $error("model byte 0 not in frame");

  frame_hi_model_a: assert property (@(posedge clk) disable iff (rst)
    (!use_cmd) |=> frame_bits_47_40 == $past(model_info_bytes_r[2]))
    else $error("model byte 2 not in frame");

  frame_ext_a: assert property (@(posedge clk) disable iff (rst)
    (use_cmd && op_mode == MODE_EXTENDED) |=> frame_bits_31_24 == $past(mode_r))
    else $error("mode register not in frame");

  frame_cmd_lo_a: assert property (@(posedge clk) disable iff (rst)
    (use_cmd && op_mode != MODE_EXTENDED) |=> frame_bits_31_24 == $past(model_info_bytes_r[0]))
    else $error("normal command frame lost model byte 0");

  frame_ext_addr_a: assert property (@(posedge clk) disable iff (rst)
    (center_side && op_mode == MODE_EXTENDED) |=> frame_bits_39_32 == $past(remote_addr_byte_r))
    else $error("extended frame lacks address byte");

  frame_ext_data_a: assert property (@(posedge clk) disable iff (rst)
    (center_side && op_mode == MODE_EXTENDED) |=> frame_bits_47_40 == $past(remote_data_byte_r))
    else $error("extended frame lacks data byte");

  term_side_a: assert property (@(posedge clk) disable iff (rst)
    (!center_side) |=> frame_bits_39_32 == $past(model_info_bytes_r[1]))
    else $error("terminal side used command bytes");

  // every code of extended mode maps to its command
  cmd_rdrep_a: assert property (@(posedge clk) disable iff (rst)
    (op_mode == MODE_EXTENDED && op_code == CODE_RD_REPLY) |-> remote_cmd == ORCR_CMD_RD_REPLY)
    else $error("read reply not decoded");

  cmd_rdreq_a: assert property (@(posedge clk) disable iff (rst)
    (op_mode == MODE_EXTENDED && op_code == CODE_RD_REQ && !read_ack_select) |-> remote_cmd == ORCR_CMD_RD_REQ)
    else $error("read request not decoded");

  cmd_wrrep_a: assert property (@(posedge clk) disable iff (rst)
    (op_mode == MODE_EXTENDED && op_code == CODE_WR_REPLY) |-> remote_cmd == ORCR_CMD_WR_REPLY)
    else $error("write reply not decoded");

  cmd_wrreq_a: assert property (@(posedge clk) disable iff (rst)
    (op_mode == MODE_EXTENDED && op_code == CODE_WR_REQ) |-> remote_cmd == ORCR_CMD_WR_REQ)
    else $error("write request not decoded");

  // read data stand one cycle, then fall back to zero
  rdata_idle_a: assert property (@(posedge clk) disable iff (rst)
    (!reg_rd) |=> reg_rdata == 8'h00)
    else $error("read data outside a read");

  rdata_cnt_a: assert property (@(posedge clk) disable iff (rst)
    hit(reg_rd, reg_addr, ADDR_TXCNT) |=> reg_rdata == $past(tx_count))
    else $error("counter readback wrong");

  rdata_mode_a: assert property (@(posedge clk) disable iff (rst)
    hit(reg_rd, reg_addr, ADDR_MODE) |=> reg_rdata == $past(mode_r))
    else $error("mode readback wrong");

  rdata_addr_a: assert property (@(posedge clk) disable iff (rst)
    hit(reg_rd, reg_addr, ADDR_ADDR) |=> reg_rdata == $past(remote_addr_byte_r))
    else $error("address byte read wrong");

  rdata_data_a: assert property (@(posedge clk) disable iff (rst)
    hit(reg_rd, reg_addr, ADDR_DATA) |=> reg_rdata == $past(remote_data_byte_r))
    else $error("data byte read wrong");

  rdata_model1_a: assert property (@(posedge clk) disable iff (rst)
    hit(reg_rd, reg_addr, ADDR_MODEL1) |=> reg_rdata == $past(model_info_bytes_r[1]))
    else $error("model byte 1 read wrong");

  rdata_ctrl_a: assert property (@(posedge clk) disable iff (rst)
    hit(reg_rd, reg_addr, ADDR_CTRL) |=> reg_rdata == 8'h00)
    else $error("control register read not zero");

  // counter holds without a packet; a nonzero control write is ignored
  count_hold_a: assert property (@(posedge clk) disable iff (rst)
    (!tx_valid_pkt && !cnt_clr) |=> $stable(tx_count))
    else $error("tx counter moved without a packet");

  clr_nz_a: assert property (@(posedge clk) disable iff (rst)
    (hit(reg_wr, reg_addr, ADDR_CTRL) && reg_wdata != CTRL_CLEAR_VAL && !tx_valid_pkt) |=> $stable(tx_count))
    else $error("nonzero control write cleared counter");

  count_max_inc_a: assert property (@(posedge clk) disable iff (rst)
    (tx_count == CNT_MAX && tx_valid_pkt && !cnt_clr) |=> tx_count == CNT_MAX)
    else $error("tx counter wrapped on a packet");
endmodule : orcr_regs

// File: dv/orcr_frame_model.sv
`timescale 1ns/10ps
// far-end frame engine stand-in: sent packets and command frames
module orcr_frame_model (
  input wire logic clk,
  output logic remote_cmd_send,
  output logic tx_valid_pkt
);
  initial begin
    remote_cmd_send = 1'b0;
    tx_valid_pkt = 1'b0;
  end
  // a gap after each strobe so no two packets merge into one pulse
  task send_pkts(input int n);
    repeat (n) begin
      @(posedge clk);
      tx_valid_pkt <= 1'b1;
      @(posedge clk);
      tx_valid_pkt <= 1'b0;
    end
  endtask : send_pkts
  // level held for the whole command frame
  task cmd_frame(input logic v);
    @(posedge clk);
    remote_cmd_send <= v;
  endtask : cmd_frame
endmodule : orcr_frame_model

// File: dv/orcr_regs_tb_top.sv
`timescale 1ns/10ps
module orcr_regs_tb_top;
  import orcr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic center_side = 1'b1;
  logic [7:0] reg_rdata, fb24, fb32, fb40;
  logic remote_cmd_send, tx_valid_pkt, mode_reserved;
  logic [1:0] op_mode;
  orcr_cmd_t remote_cmd;
  int error_cnt = 0;
  int compares = 0;
  orcr_cmd_t exp_cmd [4] = '{ORCR_CMD_RD_REPLY, ORCR_CMD_RD_REQ, ORCR_CMD_WR_REPLY, ORCR_CMD_WR_REQ};

  // 125 MHz clock
  initial forever #4 clk = ~clk;

  orcr_regs dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .center_side(center_side), .remote_cmd_send(remote_cmd_send),
    .tx_valid_pkt(tx_valid_pkt), .frame_bits_31_24(fb24), .frame_bits_39_32(fb32), .frame_bits_47_40(fb40),
    .remote_cmd(remote_cmd), .op_mode(op_mode), .mode_reserved(mode_reserved));
  orcr_frame_model fm (.clk(clk), .remote_cmd_send(remote_cmd_send), .tx_valid_pkt(tx_valid_pkt));

  ////////////////////////////////////////
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data only stand in the cycle after the strobe
  task rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(n, reg_rdata, e);
  endtask : rd_chk
  // write then read with no gap; read data stand one cycle, then zero
  task wr_rd_chk(input string n, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(n, reg_rdata, d);
    @(posedge clk);
    #1 chk(n, reg_rdata, 8'h00);
  endtask : wr_rd_chk
  // frame bytes lag their source by one cycle
  task settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  task end_of_test;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////
  // watchdog, well beyond the ~610 cycles of the sequence
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    end_of_test;
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd_chk("mode_rst", ADDR_MODE, 8'h22);
    rd_chk("data_rst", ADDR_DATA, 8'h00);
    rd_chk("cnt_rst", ADDR_TXCNT, 8'h00);
    rd_chk("unmapped", 8'h00, 8'h00);
    // reset leaves extended mode on, so normal mode is chosen first
    wr(ADDR_MODE, {6'h00, MODE_NORMAL});
    rd_chk("mode_norm", ADDR_MODE, 8'h20);
    wr(ADDR_MODEL0, 8'h33);
    wr(ADDR_MODEL1, 8'h11);
    wr(ADDR_MODEL2, 8'h22);
    wr_rd_chk("addr_b2b", ADDR_ADDR, 8'h5a);
    wr(ADDR_DATA, 8'ha5);
    rd_chk("addr_rw", ADDR_ADDR, 8'h5a);
    settle;
    chk("fb24_norm", fb24, 8'h33);
    chk("fb32_norm", fb32, 8'h11);
    chk("fb40_norm", fb40, 8'h22);
    fm.cmd_frame(1'b1);
    settle;
    chk("fb24_cmd", fb24, 8'h33);
    chk("fb32_cmd", fb32, 8'h5a);
    chk("fb40_cmd", fb40, 8'ha5);
    // terminal side ignores the command bytes
    @(posedge clk);
    center_side <= 1'b0;
    settle;
    chk("fb32_term", fb32, 8'h11);
    fm.cmd_frame(1'b0);
    center_side <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_MODE, {4'h0, c[1:0], MODE_EXTENDED});
      settle;
      chk("cmd", {5'h00, remote_cmd}, {5'h00, exp_cmd[c]});
    end
    chk("fb24_ext", fb24, 8'h2e);
    chk("fb32_ext", fb32, 8'h5a);
    chk("fb40_ext", fb40, 8'ha5);
    wr(ADDR_MODE, 8'h46);
    settle;
    chk("rd_ack", {5'h00, remote_cmd}, {5'h00, ORCR_CMD_RD_ACK});
    chk("op_mode_ext", {6'h00, op_mode}, {6'h00, MODE_EXTENDED});
    chk("rsv_ext", {7'h00, mode_reserved}, 8'h00);
    // software keeps to the defined modes only
    wr(ADDR_MODE, {6'h00, MODE_NORMAL});
    settle;
    chk("mode_rsv", {7'h00, mode_reserved}, 8'h00);
    chk("op_mode_norm", {6'h00, op_mode}, {6'h00, MODE_NORMAL});
    // counting, write protection, clear, saturation
    fm.send_pkts(3);
    rd_chk("cnt3", ADDR_TXCNT, 8'h03);
    wr(ADDR_TXCNT, 8'h77);
    rd_chk("cnt_ro", ADDR_TXCNT, 8'h03);
    wr(ADDR_CTRL, 8'h01);
    rd_chk("clr_nz", ADDR_TXCNT, 8'h03);
    wr(ADDR_CTRL, CTRL_CLEAR_VAL);
    rd_chk("clr", ADDR_TXCNT, 8'h00);
    rd_chk("ctrl_rd", ADDR_CTRL, 8'h00);
    fm.send_pkts(258);
    rd_chk("sat", ADDR_TXCNT, 8'hff);
    // mid-run reset brings back the defaults
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_chk("mode_rst2", ADDR_MODE, 8'h22);
    rd_chk("cnt_rst2", ADDR_TXCNT, 8'h00);
    end_of_test;
  end
endmodule : orcr_regs_tb_top
